// ---- mdcr_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// Decoded outputs trail a write by two cycles, read data by one.
module mdcr_checker (
    input wire logic clk, rst, reg_wr, config_lock, serial_check_enable,
    input wire logic demag_high_cmp_threshold, demag_low_cmp_threshold,
    input wire logic serial_out_rail_sel, serial_out_opendrain_en,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata, demag_wait_cycles,
    input wire logic [6:0] limit_blank_time_100ns,
    input wire logic [3:0] demag_wait_margin,
    input wire logic [2:0] limit_blank_time_sel,
    input wire logic [1:0] slew_rate_sel, sense_amp_gain);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic w22 = reg_wr && reg_addr == 6'h22;
    wire logic [10:0] pd = {limit_blank_time_sel, demag_wait_margin,
        demag_high_cmp_threshold, demag_low_cmp_threshold, slew_rate_sel};
    // Codes above 3 act as 3; the slowest edge raises the base, and code 3 takes a longer last step at either edge.
    function automatic logic [6:0] bt(input logic [2:0] s, input logic w);
        return (w ? 7'h37 : 7'h12) + 7'h5 * (s[2] ? 3'h3 : s)
            + (s > 3'h2 ? 7'h5 : 7'h0);
    endfunction
    a_blank_time: assert property (
        limit_blank_time_100ns == bt(limit_blank_time_sel,
        slew_rate_sel == 2'h3)) else $error("blank time");
    a_pred_write: assert property (
        w22 && !config_lock |-> ##2 pd == $past(reg_wdata[10:0], 2))
        else $error("predriver write");
    a_lock_hold: assert property (
        w22 && config_lock |-> ##2 pd == $past(pd, 2)) else $error("lock");
    a_sys_write: assert property (
        reg_wr && reg_addr == 6'h3F && reg_wdata[14:12] == 3'h5 |-> ##2
        {serial_out_rail_sel, serial_out_opendrain_en, config_lock,
        serial_check_enable} == $past({reg_wdata[11:10], reg_wdata[7:6]}, 2))
        else $error("system write");
    a_key_zero: assert property (
        reg_rdata[14:12] == 3'h0) else $error("key field");
    a_margin_time: assert property (
        !$past(rst) && !$past(rst, 2) && $stable(demag_wait_margin) |->
        demag_wait_cycles == 16'h64 * demag_wait_margin) else $error("margin");
    a_gain_read: assert property (
        $past(reg_addr) == 6'h23 && !$past(reg_wr) && $stable(sense_amp_gain)
        |-> reg_rdata[14:0] == {13'h0, sense_amp_gain}) else $error("gain");
    a_parity_bit: assert property (
        $past(reg_addr) inside {6'h22, 6'h23, 6'h3F} && !$past(reg_wr) &&
        $stable(serial_check_enable) |-> reg_rdata[15] ==
        (serial_check_enable & ~^reg_rdata[14:0])) else $error("parity");
    cover property (w22 && config_lock);
    cover property (reg_wr && reg_addr == 6'h3F && reg_wdata[14:12] != 3'h5);
    cover property (serial_check_enable && reg_rdata[15]);
endmodule // mdcr_checker
bind mdcr_regbank mdcr_checker u_chk (.*);
`default_nettype wire

// ---- mdcr_mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Host side: a request starts just after an edge; a write lasts one cycle.
module mdcr_mcu_model (
    input wire logic clk, // Bank clock.
    input wire logic [15:0] reg_rdata, // Read data.
    output var logic [5:0] reg_addr = 6'h00, // Address.
    output var logic reg_wr = 1'b0, // Write strobe.
    output var logic [15:0] reg_wdata = 16'h0000); // Write data.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        // Released data is inverted so a stale word never passes as valid.
        @(posedge clk) #1 {reg_wdata, reg_wr} = {~d, 1'b0};
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk) #1 reg_addr = a;
        @(posedge clk) #1 d = reg_rdata;
    endtask
endmodule // mdcr_mcu_model
`default_nettype wire

// ---- mdcr_parity.v ----
`timescale 1ns/100ps
`default_nettype none
// Odd parity over bits 14..0 and places it in bit 15 when enabled.
module mdcr_parity (
    input wire [15:0] data_in, // Raw register word.
    input wire enable, // Parity enable.
    output wire [15:0] data_out // Word with parity bit applied.
);
    // Odd parity, so that an all-zero word never looks valid on a stuck line.
    assign data_out = {enable & ~(^data_in[14:0]), data_in[14:0]};
endmodule // mdcr_parity
`default_nettype wire

// ---- mdcr_regbank.v ----
`timescale 1ns/100ps
`default_nettype none
`include "mdcr_regs.vh"
module mdcr_regbank (
    input wire clk, // 250 MHz clock.
    input wire rst, // Synchronous reset, active high.
    input wire [5:0] reg_addr, // Register address from the serial core.
    input wire reg_wr, // One-cycle write strobe.
    input wire [15:0] reg_wdata, // Write data.
    output reg [15:0] reg_rdata, // Registered read data.
    output reg [2:0] limit_blank_time_sel, // Blanking code.
    output reg [6:0] limit_blank_time_100ns, // Blanking time, 100 ns units.
    output reg [3:0] demag_wait_margin, // Demag margin N.
    output reg [15:0] demag_wait_cycles, // Margin in clock cycles.
    output reg demag_high_cmp_threshold, // 0 is 100 mA, 1 is 150 mA.
    output reg demag_low_cmp_threshold, // 0 is 100 mA, 1 is 150 mA.
    output reg [1:0] slew_rate_sel, // 0:1100 1:500 2:250 3:50 V/us.
    output reg [1:0] sense_amp_gain, // 0:0.4 1:1.0 2:2.5 3:5.0 V/A.
    output reg serial_out_rail_sel, // 0 analog_ldo_rail, 1 gate_drive_rail.
    output reg serial_out_opendrain_en, // 1 open drain, 0 push-pull.
    output reg config_lock, // Configuration lock.
    output reg serial_check_enable // Parity enable.
);
    // One margin step in clock cycles. The divide is exact at the
    // documented clock; a clock whose period does not divide the step
    // would round the margin down, which makes the wait shorter.
    localparam [15:0] MARGIN_CYC = `MDCR_MARGIN_UNIT_NS / `MDCR_CLK_PERIOD_NS;

    //////////////////////////////////////////////////////////////////////////
    // Storage. Each register is kept as a full word so that the read path
    // is a plain mux; bits that are not writable are held at zero by the
    // write masks and therefore never need a separate clear.
    reg [15:0] predrv_reg;
    reg [15:0] sense_reg;
    reg [15:0] sysctl_reg;

    // Write qualification and read path nets.
    wire key_ok;
    wire lock_now;
    wire hit_predrv;
    wire hit_sense;
    wire hit_sysctl;
    wire wr_predrv;
    wire wr_sense;
    wire wr_sysctl;
    wire [15:0] sysctl_next;
    wire [15:0] sysctl_view;
    wire [15:0] rd_raw;
    wire [15:0] rd_par;

    // Field views of the stored words, named so that the decode below
    // reads as settings rather than as bit positions.
    wire [2:0] blank_field;
    wire [3:0] margin_field;
    wire thr_high_field;
    wire thr_low_field;
    wire [1:0] slew_field;
    wire [1:0] gain_field;
    wire slowest_edge;

    //////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the write and read paths so that the two
    // can never disagree about which register an address names.
    assign hit_predrv = reg_addr == `MDCR_ADDR_PREDRV;
    assign hit_sense = reg_addr == `MDCR_ADDR_SENSE;
    assign hit_sysctl = reg_addr == `MDCR_ADDR_SYSCTL;

    // The key guards only the system register; a wrong key drops the write.
    // The key is compared on every write but used only at that address.
    assign key_ok = reg_wdata[`MDCR_KEY_HI:`MDCR_KEY_LO] ==
        `MDCR_KEY_VALUE;

    // The lock is taken from the stored bit, not from the write data, so
    // one write can never both unlock and modify a configuration register.
    assign lock_now = sysctl_reg[`MDCR_BIT_LOCK];

    // Write enables. The system register stays reachable while locked,
    // otherwise a set lock could only be cleared by a device reset.
    assign wr_predrv = reg_wr && hit_predrv && !lock_now;
    assign wr_sense = reg_wr && hit_sense && !lock_now;
    assign wr_sysctl = reg_wr && hit_sysctl && key_ok;

    // The system register keeps its non-writable bits; only the masked
    // fields take the new data. The key field is never stored.
    assign sysctl_next = (reg_wdata & `MDCR_SYSCTL_WMASK) |
        (sysctl_reg & ~`MDCR_SYSCTL_WMASK);

    //////////////////////////////////////////////////////////////////////////
    // Register writes. Each register has its own enable, so a write to one
    // address can never disturb another even when strobes come back to back.
    always @(posedge clk) begin
        if (rst) begin
            predrv_reg <= `MDCR_RST_PREDRV;
            sense_reg <= `MDCR_RST_SENSE;
            sysctl_reg <= `MDCR_RST_SYSCTL;
        end else begin
            if (wr_predrv) begin
                predrv_reg <= reg_wdata & `MDCR_PREDRV_WMASK;
            end
            if (wr_sense) begin
                sense_reg <= reg_wdata & `MDCR_SENSE_WMASK;
            end
            if (wr_sysctl) begin
                sysctl_reg <= sysctl_next;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Field extraction from the stored words.
    assign blank_field = predrv_reg[`MDCR_BLANK_HI:`MDCR_BLANK_LO];
    assign margin_field = predrv_reg[`MDCR_MARGIN_HI:`MDCR_MARGIN_LO];
    assign thr_high_field = predrv_reg[`MDCR_BIT_THR_HIGH];
    assign thr_low_field = predrv_reg[`MDCR_BIT_THR_LOW];
    assign slew_field = predrv_reg[`MDCR_SLEW_HI:`MDCR_SLEW_LO];
    assign gain_field = sense_reg[`MDCR_GAIN_HI:`MDCR_GAIN_LO];

    // The slowest edge rate stretches the blanking window, because the
    // phase node takes far longer to settle at that edge speed.
    assign slowest_edge = slew_field == `MDCR_SLEW_SLOWEST;

    //////////////////////////////////////////////////////////////////////////
    // The system register is shown through its write mask, so the key
    // field and the read-only reserved bits always read as zero.
    assign sysctl_view = sysctl_reg & `MDCR_SYSCTL_WMASK;

    // Read mux. An unmapped address reads zero, or 16'h8000 with parity enabled,
    // rather than an alias of a real register, so a host with a wrong address sees it at once.
    assign rd_raw = hit_predrv ? predrv_reg :
                    hit_sense ? sense_reg :
                    hit_sysctl ? sysctl_view : 16'h0000;

    // Parity is added on the way out and never stored, so turning parity
    // on or off takes effect on the very next read of any register.

    mdcr_parity u_par (
        .data_in(rd_raw),
        .enable(sysctl_reg[`MDCR_BIT_PEN]),
        .data_out(rd_par)
    );

    // Read data is registered; it follows the address one cycle later.
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rd_par;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Decoded settings, registered so the analog side sees clean levels.
    // They trail the stored words by one cycle; the reset values match
    // what the reset words decode to, so no glitch follows reset.
    always @(posedge clk) begin
        if (rst) begin
            limit_blank_time_sel <= 3'h0;
            limit_blank_time_100ns <= `MDCR_BLANK_FAST0;
            demag_wait_margin <= `MDCR_RST_MARGIN;
            demag_wait_cycles <= {12'h000, `MDCR_RST_MARGIN} * MARGIN_CYC;
            demag_high_cmp_threshold <= 1'b0;
            demag_low_cmp_threshold <= 1'b0;
            slew_rate_sel <= 2'h0;
            sense_amp_gain <= 2'h0;
            serial_out_rail_sel <= 1'b0;
            serial_out_opendrain_en <= 1'b0;
            config_lock <= 1'b0;
            serial_check_enable <= 1'b0;
        end else begin
            limit_blank_time_sel <= blank_field;
            // Codes above 3 are undefined; they fall back to code 3 times.
            if (slowest_edge) begin
                case (blank_field)
                    3'h0: limit_blank_time_100ns <= `MDCR_BLANK_SLOW0;
                    3'h1: limit_blank_time_100ns <= `MDCR_BLANK_SLOW1;
                    3'h2: limit_blank_time_100ns <= `MDCR_BLANK_SLOW2;
                    default: limit_blank_time_100ns <= `MDCR_BLANK_SLOW3;
                endcase
            end else begin
                case (blank_field)
                    3'h0: limit_blank_time_100ns <= `MDCR_BLANK_FAST0;
                    3'h1: limit_blank_time_100ns <= `MDCR_BLANK_FAST1;
                    3'h2: limit_blank_time_100ns <= `MDCR_BLANK_FAST2;
                    default: limit_blank_time_100ns <= `MDCR_BLANK_FAST3;
                endcase
            end
            // The margin is handed over both as the code and as a cycle
            // count, so the timer downstream needs no multiplier of its own.
            demag_wait_margin <= margin_field;
            demag_wait_cycles <= {12'h000, margin_field} * MARGIN_CYC;
            demag_high_cmp_threshold <= thr_high_field;
            demag_low_cmp_threshold <= thr_low_field;
            slew_rate_sel <= slew_field;
            sense_amp_gain <= gain_field;
            // System settings; these are never blocked by the lock.
            serial_out_rail_sel <= sysctl_reg[`MDCR_BIT_RAIL];
            serial_out_opendrain_en <= sysctl_reg[`MDCR_BIT_ODEN];
            config_lock <= sysctl_reg[`MDCR_BIT_LOCK];
            serial_check_enable <= sysctl_reg[`MDCR_BIT_PEN];
        end
    end
endmodule // mdcr_regbank
`default_nettype wire

// ---- mdcr_regs.vh ----
// What this block does
// - Blanking code picks time, slower when slowest slew.
// - Demag wait margin is N times 400 ns.
// - Bit 3 sets high-side demag threshold.
// - Bit 2 sets low-side demag threshold.
// - Slew code selects edge speed, code 3 slowest.
// - Sense gain code selects amplifier gain, resets 0.
// - Bit 11 selects serial output supply rail.
// - Bit 10 selects push-pull or open-drain output.
// - Bit 7 locks configuration registers, resets 0.
// - Bit 6 enables parity on serial transfers.
// - Bit 15 reads parity when enabled, else zero.
`ifndef MDCR_REGS_VH
`define MDCR_REGS_VH
`define MDCR_ADDR_PREDRV 6'h22
`define MDCR_ADDR_SENSE 6'h23
`define MDCR_ADDR_SYSCTL 6'h3F
`define MDCR_RST_PREDRV 16'h0080
`define MDCR_RST_SENSE 16'h0000
`define MDCR_RST_SYSCTL 16'h0008
`define MDCR_PREDRV_WMASK 16'h07FF
`define MDCR_SENSE_WMASK 16'h0003
`define MDCR_SYSCTL_WMASK 16'h0CF8
`define MDCR_KEY_VALUE 3'h5
`define MDCR_KEY_HI 14
`define MDCR_KEY_LO 12
`define MDCR_PAR_BIT 15
`define MDCR_BIT_RAIL 11
`define MDCR_BIT_ODEN 10
`define MDCR_BIT_LOCK 7
`define MDCR_BIT_PEN 6
`define MDCR_SLEW_SLOWEST 2'h3
`define MDCR_RST_MARGIN 4'h8
`define MDCR_BLANK_HI 10
`define MDCR_BLANK_LO 8
`define MDCR_MARGIN_HI 7
`define MDCR_MARGIN_LO 4
`define MDCR_BIT_THR_HIGH 3
`define MDCR_BIT_THR_LOW 2
`define MDCR_SLEW_HI 1
`define MDCR_SLEW_LO 0
`define MDCR_GAIN_HI 1
`define MDCR_GAIN_LO 0
`define MDCR_MARGIN_UNIT_NS 400
`define MDCR_CLK_PERIOD_NS 4
// Blanking times in units of 100 ns.
`define MDCR_BLANK_SLOW0 7'h37
`define MDCR_BLANK_SLOW1 7'h3C
`define MDCR_BLANK_SLOW2 7'h41
`define MDCR_BLANK_SLOW3 7'h4B
`define MDCR_BLANK_FAST0 7'h12
`define MDCR_BLANK_FAST1 7'h17
`define MDCR_BLANK_FAST2 7'h1C
`define MDCR_BLANK_FAST3 7'h26
`endif

// ---- motor_driver_config_registers_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module motor_driver_config_registers_tb_top;
    logic clk = 1'b0, rst = 1'b1, reg_wr, config_lock, serial_check_enable;
    logic demag_high_cmp_threshold, demag_low_cmp_threshold;
    logic serial_out_rail_sel, serial_out_opendrain_en;
    logic [15:0] reg_wdata, reg_rdata, demag_wait_cycles, v;
    logic [6:0] limit_blank_time_100ns;
    logic [5:0] reg_addr;
    logic [3:0] demag_wait_margin;
    logic [2:0] limit_blank_time_sel;
    logic [1:0] slew_rate_sel, sense_amp_gain;
    int n_fail = 0, tests_run = 0;
    mdcr_regbank dut (.*);
    mdcr_mcu_model mcu (.*);
    // The whole run is well under a microsecond, so the limit is generous.
    initial forever #2 clk = ~clk;
    initial begin #20000 n_fail++; end_sim; end
    task automatic chk(input logic [15:0] g, e);
        tests_run++;
        if (g !== e) begin n_fail++; $display("wrong value %0t %h %h", $time, g, e); end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        mcu.rd(a, v); chk(v, e);
    endtask
    task automatic end_sim;
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Reset values, and an unmapped place that reads zero.
    task automatic t_reset;
        rchk(6'h22, 16'h0080);
        rchk(6'h23, 16'h0000);
        rchk(6'h3F, 16'h0008);
        rchk(6'h10, 16'h0000);
    endtask
    // Reserved bits stay clear; blanking follows the slew setting.
    task automatic t_pred;
        mcu.wr(6'h22, 16'hFFFF); rchk(6'h22, 16'h07FF);
        chk(limit_blank_time_100ns, 16'h004B);
        chk(demag_wait_cycles, 16'h05DC);
        chk({demag_high_cmp_threshold, demag_low_cmp_threshold,
            slew_rate_sel}, 16'h000F);
        mcu.wr(6'h22, 16'h0100); rchk(6'h22, 16'h0100);
        chk(limit_blank_time_100ns, 16'h0017);
    endtask
    // Key refusal, lock, parity, then unlock and a config write.
    task automatic t_sys;
        mcu.wr(6'h3F, 16'h4CC8); rchk(6'h3F, 16'h0008);
        mcu.wr(6'h3F, 16'h5CC8); rchk(6'h3F, 16'h0CC8);
        chk({serial_out_rail_sel, serial_out_opendrain_en, config_lock,
            serial_check_enable}, 16'h000F);
        mcu.wr(6'h23, 16'h0003); rchk(6'h23, 16'h8000);
        mcu.wr(6'h22, 16'h0000); rchk(6'h22, 16'h0100);
        mcu.wr(6'h3F, 16'h5008); rchk(6'h3F, 16'h0008);
        mcu.wr(6'h23, 16'h0002); rchk(6'h23, 16'h0002);
        chk(sense_amp_gain, 16'h0002);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_reset; t_pred; t_sys; end_sim;
    end
endmodule // motor_driver_config_registers_tb_top
`default_nettype wire
